// >>> rtl/serial_dac_write_port.sv
// three-wire serial write port feeding the converter output word
//
// Summary of operation
// - each of the first 24 falling link clock edges in a frame shifts one data bit in.
// - frame select low opens a frame; following falling edges carry bits.
// - after the 24th falling edge the word is buffered and updates the converter value when the converter takes it; a full buffer loses it.
// - frame select rising before the 24th edge discards the partial word.
`timescale 1ns/1ps
module serial_dac_write_port
#(
    parameter int WORD_W = dac_port_pkg::FRAME_BITS,
    parameter int DEPTH = dac_port_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // serial link pins
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_sync_n,
    // converter side
    output logic [WORD_W-1:0] o_analog_output,
    output logic o_update,
    input wire logic i_conv_ready,
    // status
    output logic o_abort,
    output logic o_overrun
);
    import dac_port_pkg::*;

    // refuse parameter values the capture logic cannot serve
    if (WORD_W != FRAME_BITS) begin : g_bad_width
        $error("word width must match frame length");
    end
    // the bit counter must reach the last bit index of a frame
    if ((1 << CNT_W) <= FRAME_BITS - 1) begin : g_bad_count
        $error("bit counter too narrow for frame");
    end

    ////////////////////////////////////////////////////////////////////////
    // three-stage pin sampling; stage one feeds only stage two
    link_s s1, s2, s3, pin;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1 <= '{sclk: 1'b1, din: 1'b0, sync_n: 1'b1};
            s2 <= '{sclk: 1'b1, din: 1'b0, sync_n: 1'b1};
            s3 <= '{sclk: 1'b1, din: 1'b0, sync_n: 1'b1};
            pin <= '{sclk: 1'b1, din: 1'b0, sync_n: 1'b1};
        end else begin
            s1 <= '{sclk: i_sclk, din: i_din, sync_n: i_sync_n};
            s2 <= s1;
            s3 <= s2;
            // a level counts once the later two stages agree
            if (s2.sclk == s3.sclk) pin.sclk <= s3.sclk;
            if (s2.din == s3.din) pin.din <= s3.din;
            if (s2.sync_n == s3.sync_n) pin.sync_n <= s3.sync_n;
        end
    end

    // edge events on the filtered levels
    logic sclk_fall;
    logic sync_rise;
    logic sclk_q;
    logic sync_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            sclk_q <= pin.sclk;
            sync_q <= pin.sync_n;
        end
    end
    assign sclk_fall = sclk_q && !pin.sclk;
    assign sync_rise = !sync_q && pin.sync_n;

    ////////////////////////////////////////////////////////////////////////
    // frame state, bit counter and shift register
    frame_e state;
    logic [CNT_W-1:0] bit_cnt;
    logic [WORD_W-1:0] shift;
    logic word_done;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= CNT_RESET;
            shift <= WORD_RESET;
            word_done <= 1'b0;
        end else begin
            word_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    bit_cnt <= CNT_RESET;
                    if (!pin.sync_n) state <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (sync_rise || pin.sync_n) begin
                        state <= ST_IDLE;
                        bit_cnt <= CNT_RESET;
                    end else if (sclk_fall) begin
                        shift <= {shift[WORD_W-2:0], pin.din};
                        if (bit_cnt == CNT_W'(FRAME_BITS - 1)) begin
                            word_done <= 1'b1;
                            state <= ST_WAIT;
                            bit_cnt <= CNT_RESET;
                        end else begin
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    // extra edges after the word are ignored until select rises
                    if (pin.sync_n) state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // word buffer between capture and converter
    logic fifo_ready;
    logic fifo_valid;
    logic [WORD_W-1:0] fifo_data;
    logic take;
    word_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(word_done),
        .i_data(shift),
        .o_ready(fifo_ready),
        .o_valid(fifo_valid),
        .o_data(fifo_data),
        .i_ready(take)
    );
    assign take = fifo_valid && i_conv_ready;

    // converter value holds until the converter takes the next buffered word
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_analog_output <= WORD_RESET;
            o_update <= 1'b0;
        end else begin
            o_update <= take;
            if (take) o_analog_output <= fifo_data;
        end
    end

    // status pulses; a full buffer cannot stall the host so the word is lost
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_abort <= 1'b0;
            o_overrun <= 1'b0;
        end else begin
            o_abort <= (state == ST_SHIFT) && pin.sync_n;
            o_overrun <= word_done && !fifo_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_abort_seen;
        (state == ST_SHIFT) && pin.sync_n;
    endsequence

    a_abort_no_word: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_abort_seen |=> !word_done && state == ST_IDLE)
        else $error("aborted frame produced a word");
    a_count_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state == ST_IDLE |=> bit_cnt == CNT_RESET)
        else $error("bit count not restarted");
    a_done_on_last: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(word_done) |-> $past(bit_cnt) == CNT_W'(FRAME_BITS - 1) && state == ST_WAIT)
        else $error("word completed at wrong bit");
    a_shift_on_fall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state == ST_SHIFT && !pin.sync_n && sclk_fall
        |=> shift[0] == $past(pin.din))
        else $error("bit not shifted on falling edge");
    a_hold_no_fall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !sclk_fall |=> $stable(shift))
        else $error("shift moved without clock edge");
    a_frame_open: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state == ST_IDLE && !pin.sync_n |=> state == ST_SHIFT)
        else $error("frame select did not open frame");
    a_output_update: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        take |=> o_update && o_analog_output == $past(fifo_data))
        else $error("converter not updated");
    a_output_steady: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !take |=> $stable(o_analog_output))
        else $error("converter changed without word");

    // word completion steps: last edge taken, then word handed to the buffer
    sequence s_last_edge;
        state == ST_SHIFT && !pin.sync_n && sclk_fall && bit_cnt == CNT_W'(FRAME_BITS - 1);
    endsequence

    sequence s_word_out;
        word_done && state == ST_WAIT;
    endsequence

    sequence s_word_lost;
        word_done && !fifo_ready;
    endsequence

    a_last_bit_done: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_last_edge |=> s_word_out)
        else $error("last bit did not complete the word");
    a_word_stored: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        word_done && fifo_ready |=> fifo_valid)
        else $error("completed word not buffered");
    a_overrun_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_word_lost |=> o_overrun)
        else $error("lost word not flagged");
    // trailing edges after a full word must leave the captured word alone
    a_wait_ignores: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state == ST_WAIT |=> $stable(shift) && !word_done)
        else $error("edges after the word were taken");
    // an abort shows as exactly one status pulse
    a_abort_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_abort_seen |=> o_abort)
        else $error("abort not flagged");
    a_abort_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_abort |=> !o_abort)
        else $error("abort flag held too long");
endmodule

// >>> rtl/dac_port_pkg.sv
// shared constants and carrier types for the serial converter write port
package dac_port_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
    localparam logic [FRAME_BITS-1:0] WORD_RESET = 24'h00_0000;
    localparam int FIFO_DEPTH = 16;
    // link clock period the bench drives, in ns; each phase must span four system clocks
    localparam int LINK_PERIOD_NS = 125;
    localparam int CLK_PERIOD_NS = 10;
    localparam int LINK_CYCLES = LINK_PERIOD_NS / CLK_PERIOD_NS;

    // synchronised view of the three link pins
    typedef struct packed {
        logic sclk;
        logic din;
        logic sync_n;
    } link_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_WAIT = 2'b10
    } frame_e;
endpackage

// >>> rtl/word_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);

    // pointers wrap on their extra bit, so only powers of two are served
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign o_valid = wr_ptr != rd_ptr;
    assign o_data = mem[rd_ptr[AW-1:0]];

    // storage has no reset, only pointers do
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end

    // pointer update
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// >>> test/link_host.sv
// behavioural host for the three-wire link; link clock rests high between frames
`timescale 1ns/1ps
module link_host
    import dac_port_pkg::*;
#(
    parameter realtime HALF_NS = LINK_PERIOD_NS / 2.0
) (
    // link pins
    output logic o_sclk,
    output logic o_din,
    output logic o_sync_n
);
    initial begin
        o_sclk = 1'b1;
        o_din = 1'b0;
        o_sync_n = 1'b1;
    end

    // one frame; fewer than 24 edges means select rises early
    task automatic frame(input logic [FRAME_BITS-1:0] w, input int nbits);
        o_sync_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            o_din = (i < FRAME_BITS) ? w[FRAME_BITS-1-i] : ~w[0];
            #(HALF_NS) o_sclk = 1'b0;
            #(HALF_NS) o_sclk = 1'b1;
        end
        #(HALF_NS) o_sync_n = 1'b1;
        // released data line must not keep its last level
        o_din = ~o_din;
    endtask
endmodule

// >>> test/test_serial_dac_write_port.sv
// self-checking bench for the serial converter write port
`timescale 1ns/1ps
module test_serial_dac_write_port;
    import dac_port_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_conv_ready = 1'b1;
    logic sclk, din, sync_n, o_update, o_abort, o_overrun;
    logic [FRAME_BITS-1:0] o_analog_output;
    logic [FRAME_BITS-1:0] exp_q[$];
    logic prev_abort = 1'b0;
    int bad_count = 0;
    int n_compared = 0;
    int n_abort = 0;
    int n_over = 0;
    int n_upd = 0;
    int upd_before;

    initial forever #5 i_clk = ~i_clk;

    serial_dac_write_port #(.WORD_W(FRAME_BITS), .DEPTH(FIFO_DEPTH)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_din(din),
        .i_sync_n(sync_n), .o_analog_output(o_analog_output), .o_update(o_update),
        .i_conv_ready(i_conv_ready), .o_abort(o_abort), .o_overrun(o_overrun));
    link_host host (.o_sclk(sclk), .o_din(din), .o_sync_n(sync_n));

    task automatic check_word(input string what, input logic [FRAME_BITS-1:0] e,
                              input logic [FRAME_BITS-1:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_count(input string what, input int e, input int g);
        n_compared++;
        if (g != e) begin
            bad_count++;
            $display("ERROR %s expected %0d seen %0d", what, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // only whole frames enter the reference queue
    task automatic send(input logic [FRAME_BITS-1:0] v, input int nbits);
        if (nbits >= FRAME_BITS) exp_q.push_back(v);
        @(posedge i_clk);
        #1 host.frame(v, nbits);
        repeat (20) @(posedge i_clk);
    endtask

    // monitor: every update must match the oldest whole frame sent
    always @(posedge i_clk) begin
        prev_abort <= o_abort;
        if (o_abort === 1'b1 && prev_abort !== 1'b1) n_abort++;
        if (o_overrun === 1'b1) n_over++;
        if (o_update === 1'b1) begin
            n_upd++;
            if (exp_q.size() == 0) check_count("spare update", 0, 1);
            else check_word("analog output", exp_q.pop_front(), o_analog_output);
        end
    end

    // watchdog sized well above the planned frame traffic
    initial begin
        #400_000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h53df_d611));
        repeat (8) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        check_word("reset output", WORD_RESET, o_analog_output);
        repeat (5) @(posedge i_clk);
        // boundary words, some frames with trailing edges that must be ignored
        for (int i = 0; i < 4; i++) begin
            send(i[0] ? 24'h80_0001 : 24'h7F_FFFE, FRAME_BITS + i);
        end
        $display("test plain frames done");
        // aborts after the first, a middle and the last-but-one bit
        for (int i = 0; i < 3; i++) begin
            send(24'($urandom), i * 11 + 1);
            send(24'($urandom), FRAME_BITS);
        end
        check_count("abort pulses", 3, n_abort);
        $display("test aborts done");
        // random words with the converter accepting at random
        for (int i = 0; i < 12; i++) begin
            @(posedge i_clk);
            #1 i_conv_ready = 1'($urandom);
            send(24'($urandom), FRAME_BITS);
        end
        @(posedge i_clk);
        #1 i_conv_ready = 1'b1;
        repeat (60) @(posedge i_clk);
        $display("test random frames done");
        // fill the buffer with the converter stalled, one more word overruns
        @(posedge i_clk);
        #1 i_conv_ready = 1'b0;
        upd_before = n_upd;
        for (int i = 0; i < FIFO_DEPTH; i++) send(24'(i * 24'h01_0101), FRAME_BITS);
        @(posedge i_clk);
        #1 host.frame(24'hAB_CDEF, FRAME_BITS);
        repeat (20) @(posedge i_clk);
        check_count("overrun pulses", 1, n_over);
        check_count("updates while stalled", upd_before, n_upd);
        @(posedge i_clk);
        #1 i_conv_ready = 1'b1;
        repeat (100) @(posedge i_clk);
        check_count("words left", 0, exp_q.size());
        $display("test buffer fill and drain done");
        tally_and_finish();
    end
endmodule
